// *** ciw_pkg.sv ***
package ciw_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] CIW_OFF_CTRL = 8'h00;
  localparam logic [7:0] CIW_OFF_IE   = 8'h04;
  localparam logic [7:0] CIW_OFF_FLAG = 8'h08;
  localparam logic [7:0] CIW_OFF_GIE  = 8'h0c;

  // comparator_control_reg fields
  localparam int CIW_BIT_RESULT  = 5;
  localparam int CIW_BIT_SEL_HI  = 4;
  localparam int CIW_BIT_SEL_LO  = 3;
  // irq_enable_byte (mask) and wake_flag_byte (status) share bit 4; wake_flag_byte also holds wake enable at bit 2
  localparam int CIW_BIT_IE      = 4;
  localparam int CIW_BIT_FLAG    = 4;
  localparam int CIW_BIT_WAKE_EN = 2;
  // global interrupt enable register
  localparam int CIW_BIT_GIE     = 0;

  localparam logic [11:0] CIW_IRQ_VECTOR = 12'h00f;

  localparam logic [1:0]  CIW_HTRANS_IDLE = 2'h0;
  localparam logic        CIW_HRESP_OKAY  = 1'b0;
  localparam logic [31:0] CIW_RDATA_ZERO  = 32'h00000000;

  typedef enum {CIW_CMP_PLAIN, CIW_CMP_PIN, CIW_OPAMP} ciw_mode_t;

  typedef struct packed {
    logic irq;
    logic wake;
    logic to_vector;
    logic to_next;
  } ciw_core_t;

  function automatic ciw_mode_t ciw_mode(input logic hi, input logic lo);
    if (hi && lo)
      return CIW_OPAMP;
    else if (hi)
      return CIW_CMP_PIN;
    else
      return CIW_CMP_PLAIN;
  endfunction

  function automatic logic ciw_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

endpackage

// *** ciw_sync.sv ***
`timescale 1ns/100ps
module ciw_sync (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // meta feeds only the second stage
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta <= 1'b0;
      q    <= 1'b0;
    end
    else if (ce)
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// *** ciw_sticky.sv ***
`timescale 1ns/100ps
module ciw_sticky (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic ce,
  input  wire logic set,
  input  wire logic clr,
  output logic      q
);
  // a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      q <= 1'b0;
    else if (ce)
      q <= set | (q & ~clr);
  end
endmodule

// *** ciw_comparator_ctrl.sv ***
`timescale 1ns/100ps
// What this block does
// - result bit 5 of control holds outcome
// - select one-zero drives outcome onto result pin
// - select one-one: opamp mode, Schmitt trigger off
// - opamp mode: no interrupt, no wake
// - any outcome change outside opamp mode sets the flag, while awake or with wake enable
// - flag cleared only by software
// - interrupt needs enable bit and global enable
// - wake enable keeps comparator alive in sleep
// - change during sleep wakes the core
// - enabled, globally disabled: resume after sleep
// - enabled and global: jump to vector 0x00F
module ciw_comparator_ctrl (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              ce,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic              cmp_raw,
  input  wire logic              core_sleeping,
  input  wire logic              irq_on_instr,
  input  wire logic              irq_off_instr,
  output logic                   result_pin_o,
  output logic                   result_pin_oe,
  output logic                   schmitt_en,
  output logic                   comparator_on,
  output ciw_pkg::ciw_core_t     core,
  output logic [11:0]            irq_vector
);
  import ciw_pkg::*;

  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        take;
  logic        output_select_hi;
  logic        output_select_lo;
  logic        compare_irq_enable;
  logic        compare_wake_enable;
  logic        compare_irq_flag;
  logic        global_irq_en;
  logic        compare_result_bit;
  logic        cmp_sync;
  logic        active;
  logic        change;
  logic        flag_clr;
  logic        wake_evt;
  ciw_mode_t   mode;
  logic [31:0] next_rdata;

  assign take = hsel & hready & htrans[1] & ce;
  assign mode = ciw_mode(output_select_hi, output_select_lo);

  // bus: address phase captured, write applied in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend <= take & hwrite;
      if (take && hwrite)
        wr_addr <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp     <= CIW_HRESP_OKAY;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= CIW_HRESP_OKAY;
    end
  end

  always_comb
  begin
    next_rdata = CIW_RDATA_ZERO;
    if (ciw_hit(haddr[7:0], CIW_OFF_CTRL))
    begin
      next_rdata[CIW_BIT_RESULT] = compare_result_bit;
      next_rdata[CIW_BIT_SEL_HI] = output_select_hi;
      next_rdata[CIW_BIT_SEL_LO] = output_select_lo;
    end
    else if (ciw_hit(haddr[7:0], CIW_OFF_IE))
      next_rdata[CIW_BIT_IE] = compare_irq_enable;
    else if (ciw_hit(haddr[7:0], CIW_OFF_FLAG))
    begin
      next_rdata[CIW_BIT_FLAG]    = compare_irq_flag;
      next_rdata[CIW_BIT_WAKE_EN] = compare_wake_enable;
    end
    else if (ciw_hit(haddr[7:0], CIW_OFF_GIE))
      next_rdata[CIW_BIT_GIE] = global_irq_en;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= CIW_RDATA_ZERO;
    else if (take && !hwrite)
      hrdata <= next_rdata;
  end

  // software-written control
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      output_select_hi    <= 1'b0;
      output_select_lo    <= 1'b0;
      compare_irq_enable  <= 1'b0;
      compare_wake_enable <= 1'b0;
    end
    else if (ce && wr_pend)
    begin
      if (ciw_hit(wr_addr, CIW_OFF_CTRL))
      begin
        output_select_hi <= hwdata[CIW_BIT_SEL_HI];
        output_select_lo <= hwdata[CIW_BIT_SEL_LO];
      end
      else if (ciw_hit(wr_addr, CIW_OFF_IE))
        compare_irq_enable <= hwdata[CIW_BIT_IE];
      else if (ciw_hit(wr_addr, CIW_OFF_FLAG))
        compare_wake_enable <= hwdata[CIW_BIT_WAKE_EN];
    end
  end

  // instruction pulses take priority over a bus write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      global_irq_en <= 1'b0;
    else if (ce)
    begin
      if (irq_on_instr)
        global_irq_en <= 1'b1;
      else if (irq_off_instr)
        global_irq_en <= 1'b0;
      else if (wr_pend && ciw_hit(wr_addr, CIW_OFF_GIE))
        global_irq_en <= hwdata[CIW_BIT_GIE];
    end
  end

  ciw_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .d       (cmp_raw),
    .q       (cmp_sync)
  );

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      compare_result_bit <= 1'b0;
    else if (ce)
      compare_result_bit <= cmp_sync;
  end

  // comparator works outside opamp mode, and in sleep only with wake enable
  assign active   = (mode != CIW_OPAMP) & (~core_sleeping | compare_wake_enable);
  assign change   = active & (cmp_sync != compare_result_bit);
  assign flag_clr = wr_pend & ciw_hit(wr_addr, CIW_OFF_FLAG) & hwdata[CIW_BIT_FLAG];
  assign wake_evt = change & core_sleeping & compare_wake_enable;

  ciw_sticky u_flag (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .set     (change),
    .clr     (flag_clr),
    .q       (compare_irq_flag)
  );

  // core-facing outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      core       <= '0;
      irq_vector <= 12'h000;
    end
    else if (ce)
    begin
      core.irq       <= compare_irq_flag & compare_irq_enable & global_irq_en
                        & (mode != CIW_OPAMP);
      core.wake      <= wake_evt;
      core.to_vector <= wake_evt & compare_irq_enable & global_irq_en;
      core.to_next   <= wake_evt & ~(compare_irq_enable & global_irq_en);
      irq_vector     <= CIW_IRQ_VECTOR;
    end
  end

  // pin and analog controls
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      result_pin_o  <= 1'b0;
      result_pin_oe <= 1'b0;
      schmitt_en    <= 1'b1;
      comparator_on <= 1'b1;
    end
    else if (ce)
    begin
      result_pin_o  <= compare_result_bit;
      result_pin_oe <= mode == CIW_CMP_PIN;
      schmitt_en    <= mode != CIW_OPAMP;
      comparator_on <= ~core_sleeping | compare_wake_enable;
    end
  end

  a_result_tracks: assert property (@(posedge hclk) disable iff (!hresetn)
    ce |=> compare_result_bit == $past(cmp_sync))
    else $error("result bit lags sync");

  a_pin_drives: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mode == CIW_CMP_PIN |=> result_pin_oe && result_pin_o == $past(compare_result_bit))
    else $error("result pin not driven");

  a_opamp_schmitt: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && output_select_hi && output_select_lo |=> !schmitt_en && !result_pin_oe)
    else $error("schmitt still on in opamp mode");

  a_opamp_silent: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mode == CIW_OPAMP |=> !core.irq && !core.wake)
    else $error("opamp mode raised event");

  a_change_flags: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mode != CIW_OPAMP && (!core_sleeping || compare_wake_enable) && cmp_sync != compare_result_bit
    |=> compare_irq_flag) else $error("change did not set flag");

  a_flag_sticks: assert property (@(posedge hclk) disable iff (!hresetn)
    compare_irq_flag && !(ce && flag_clr) |=> compare_irq_flag)
    else $error("flag dropped by hardware");

  a_irq_gated: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(core.irq) |-> $past(compare_irq_enable) && $past(global_irq_en) && $past(compare_irq_flag))
    else $error("irq without enables");

  a_sleep_wake: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && core_sleeping && compare_wake_enable && mode != CIW_OPAMP && cmp_sync != compare_result_bit
    |=> core.wake && comparator_on) else $error("no wake in sleep");

  a_resume_next: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wake_evt && compare_irq_enable && !global_irq_en |=> core.to_next && !core.to_vector)
    else $error("wrong resume point");

  a_vector_jump: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wake_evt && compare_irq_enable && global_irq_en |=> core.to_vector && irq_vector == CIW_IRQ_VECTOR)
    else $error("vector not taken");

  a_single_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && change ##1 ce && $stable(cmp_sync) |-> !change)
    else $error("one change counted twice");

  // the edge right after reset release is skipped through past(hresetn)
  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) |-> hreadyout && hresp == CIW_HRESP_OKAY)
    else $error("bus not ready or not okay");

  a_read_result: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && ciw_hit(haddr[7:0], CIW_OFF_CTRL) |=> hrdata[CIW_BIT_RESULT] == $past(compare_result_bit))
    else $error("result bit read back wrong");

  a_read_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    take && !hwrite && ciw_hit(haddr[7:0], CIW_OFF_FLAG) |=> hrdata[CIW_BIT_FLAG] == $past(compare_irq_flag))
    else $error("flag read back wrong");

  a_ie_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wr_pend && ciw_hit(wr_addr, CIW_OFF_IE) && hwdata[CIW_BIT_IE] |=> compare_irq_enable)
    else $error("irq enable not set");

  a_ie_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wr_pend && ciw_hit(wr_addr, CIW_OFF_IE) && !hwdata[CIW_BIT_IE] |=> !compare_irq_enable)
    else $error("irq enable not cleared");

  a_wake_en_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wr_pend && ciw_hit(wr_addr, CIW_OFF_FLAG) && hwdata[CIW_BIT_WAKE_EN] |=> compare_wake_enable)
    else $error("wake enable not set");

  a_wake_en_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wr_pend && ciw_hit(wr_addr, CIW_OFF_FLAG) && !hwdata[CIW_BIT_WAKE_EN] |=> !compare_wake_enable)
    else $error("wake enable not cleared");

  a_gie_on: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && irq_on_instr |=> global_irq_en)
    else $error("global enable not set by pulse");

  a_gie_off: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && irq_off_instr && !irq_on_instr |=> !global_irq_en)
    else $error("global enable not cleared by pulse");

  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && compare_irq_flag && compare_irq_enable && global_irq_en && mode != CIW_OPAMP |=> core.irq)
    else $error("irq missing with flag and enables");

  a_irq_masked: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !(compare_irq_enable && global_irq_en) |=> !core.irq)
    else $error("irq raised while masked");

  a_flag_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && flag_clr && !change |=> !compare_irq_flag)
    else $error("flag not cleared by software");

  a_awake_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !core_sleeping |=> !core.wake && !core.to_vector && !core.to_next)
    else $error("wake pulse while awake");

  a_sleep_deaf: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && core_sleeping && !compare_wake_enable |=> !core.wake)
    else $error("wake without wake enable");

  a_power_down: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && core_sleeping && !compare_wake_enable |=> !comparator_on)
    else $error("comparator left on in sleep");

  a_vector_const: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(hresetn) && $past(ce) |-> irq_vector == CIW_IRQ_VECTOR)
    else $error("vector address wrong");

  a_pin_off: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mode != CIW_CMP_PIN |=> !result_pin_oe)
    else $error("result pin driven outside pin mode");

  a_schmitt_on: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && mode != CIW_OPAMP |=> schmitt_en)
    else $error("schmitt off in comparator mode");

endmodule

// *** ciw_cmp_model.sv ***
`timescale 1ns/100ps
// analog comparator output: follows the commanded level after a delay unrelated to hclk
module ciw_cmp_model (
  input  wire logic level,
  output wire logic cmp_raw
);
  assign #7 cmp_raw = level;
endmodule

// *** ciw_comparator_ctrl_tb.sv ***
`timescale 1ns/100ps
module ciw_comparator_ctrl_tb;
  import ciw_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        lvl;
  logic        cmp_raw;
  logic        slp;
  logic        on_p;
  logic        off_p;
  logic        pin_o;
  logic        pin_oe;
  logic        sch;
  logic        c_on;
  ciw_core_t   core;
  logic [11:0] vec;
  logic [31:0] rd;
  logic [3:0]  seen;
  int          error_cnt;
  int          n_compared;

  ciw_cmp_model model (.level(lvl), .cmp_raw(cmp_raw));

  ciw_comparator_ctrl dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .cmp_raw(cmp_raw), .core_sleeping(slp), .irq_on_instr(on_p),
    .irq_off_instr(off_p), .result_pin_o(pin_o), .result_pin_oe(pin_oe), .schmitt_en(sch),
    .comparator_on(c_on), .core(core), .irq_vector(vec)
  );

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic finish_test;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      $display("wrong value at %0t ns: %s", $time, what);
      error_cnt++;
    end
  endtask

  task automatic wait_rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge hclk);
      i++;
    end
    while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1)
    begin
      $display("wrong value at %0t ns: bus hung", $time);
      error_cnt++;
      finish_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= CIW_HTRANS_IDLE;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic pulse(input logic on);
    on_p  <= on;
    off_p <= !on;
    @(posedge hclk);
    on_p  <= 1'b0;
    off_p <= 1'b0;
    cyc(3);
  endtask

  // new analog level, then collect every core event seen over eight edges
  task automatic move(input logic v);
    lvl <= v;
    seen = 4'h0;
    repeat (8)
    begin
      @(posedge hclk);
      seen = seen | core;
    end
  endtask

  task automatic t_reset;
    cyc(1);
    chk(32'(sch), 32'h1, "schmitt at reset");
    chk(32'(vec), 32'h00f, "vector");
    bus(1'b0, CIW_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "control at reset");
    chk(32'(hresp), 32'h0, "bus response");
    $display("test reset done");
  endtask

  task automatic t_flag;
    move(1'b1);
    chk(32'(seen), 32'h0, "event while masked");
    bus(1'b0, CIW_OFF_CTRL, 32'h0);
    chk(rd, 32'h20, "result high");
    bus(1'b0, CIW_OFF_FLAG, 32'h0);
    chk(rd, 32'h10, "flag on rise");
    bus(1'b1, CIW_OFF_FLAG, 32'h10);
    cyc(6);
    bus(1'b0, CIW_OFF_FLAG, 32'h0);
    chk(rd, 32'h0, "flag set twice");
    move(1'b0);
    cyc(20);
    bus(1'b0, CIW_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "result low");
    bus(1'b0, CIW_OFF_FLAG, 32'h0);
    chk(rd, 32'h10, "flag on fall, held");
    bus(1'b1, CIW_OFF_FLAG, 32'h10);
    $display("test flag done");
  endtask

  task automatic t_pin;
    bus(1'b1, CIW_OFF_CTRL, 32'h10);
    move(1'b1);
    chk(32'({pin_oe, pin_o}), 32'h3, "pin drive");
    bus(1'b1, CIW_OFF_CTRL, 32'h08);
    bus(1'b0, CIW_OFF_CTRL, 32'h0);
    chk(rd, 32'h28, "control readback");
    chk(32'(pin_oe), 32'h0, "pin released");
    bus(1'b1, CIW_OFF_FLAG, 32'h10);
    $display("test pin done");
  endtask

  task automatic t_opamp;
    bus(1'b1, CIW_OFF_IE, 32'h10);
    pulse(1'b1);
    bus(1'b0, CIW_OFF_GIE, 32'h0);
    chk(rd, 32'h1, "global enable");
    bus(1'b1, CIW_OFF_CTRL, 32'h18);
    cyc(2);
    chk(32'(sch), 32'h0, "schmitt off");
    move(1'b0);
    chk(32'(seen), 32'h0, "event in opamp");
    bus(1'b0, CIW_OFF_FLAG, 32'h0);
    chk(rd, 32'h0, "flag in opamp");
    bus(1'b1, CIW_OFF_CTRL, 32'h0);
    $display("test opamp done");
  endtask

  task automatic t_irq;
    move(1'b1);
    chk(32'(seen), 32'h8, "irq while awake");
    chk(32'(core.irq), 32'h1, "irq level");
    pulse(1'b0);
    chk(32'(core.irq), 32'h0, "irq after global off");
    bus(1'b1, CIW_OFF_FLAG, 32'h14);
    $display("test irq done");
  endtask

  task automatic t_sleep;
    slp <= 1'b1;
    cyc(2);
    chk(32'(c_on), 32'h1, "on in sleep");
    move(1'b0);
    chk(32'(seen), 32'h5, "wake to next");
    bus(1'b1, CIW_OFF_FLAG, 32'h14);
    pulse(1'b1);
    move(1'b1);
    chk(32'(seen), 32'he, "wake to vector");
    // clears flag and wake enable: comparator powers down in sleep
    bus(1'b1, CIW_OFF_FLAG, 32'h10);
    cyc(2);
    chk(32'(c_on), 32'h0, "off in sleep");
    slp <= 1'b0;
    cyc(2);
    $display("test sleep done");
  endtask

  // clock enable low: the comparator path holds still until it returns
  task automatic t_freeze;
    ce <= 1'b0;
    move(1'b0);
    chk(32'(seen), 32'h0, "event while frozen");
    ce <= 1'b1;
    cyc(6);
    bus(1'b0, CIW_OFF_FLAG, 32'h0);
    chk(rd, 32'h10, "flag after thaw");
    bus(1'b0, CIW_OFF_CTRL, 32'h0);
    chk(rd, 32'h0, "result after thaw");
    bus(1'b1, CIW_OFF_FLAG, 32'h10);
    $display("test freeze done");
  endtask

  initial
  begin
    hresetn    = 1'b0;
    ce         = 1'b1;
    hsel       = 1'b0;
    haddr      = 32'h0;
    htrans     = CIW_HTRANS_IDLE;
    hwrite     = 1'b0;
    hwdata     = 32'h0;
    lvl        = 1'b0;
    slp        = 1'b0;
    on_p       = 1'b0;
    off_p      = 1'b0;
    error_cnt  = 0;
    n_compared = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_flag();
    t_pin();
    t_opamp();
    t_irq();
    t_sleep();
    t_freeze();
    finish_test();
  end
endmodule
